// ### shared/dhh_pkg.sv
// constants for the dpll holdover history and interrupt block
// assumes a 32-bit apb host and one system clock
package dhh_pkg;
  localparam int TW_W = 32;
  localparam int CNT_W = 16;
  localparam int NSRC = 7;
  localparam int NGPIO = 2;
  localparam int ADDR_W = 12;
  // operating mode from the dpll state machine
  typedef enum logic [1:0] {
    DHH_FREE = 2'b00,
    DHH_LOCK = 2'b01,
    DHH_HOLD = 2'b10
  } dhh_mode_t;
  // interrupt sources, bit positions in flags, mask, enables and live status
  localparam int SRC_OSC_LOSS = 0;
  localparam int SRC_REF_LOSS = 1;
  localparam int SRC_APLL1_UNLOCK = 2;
  localparam int SRC_APLL2_UNLOCK = 3;
  localparam int SRC_DPLL_UNLOCK = 4;
  localparam int SRC_HOLDOVER = 5;
  localparam int SRC_SWITCHOVER = 6;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_FREE_RUN = 12'h004;
  localparam logic [11:0] OFS_IRQ_CTRL = 12'h008;
  localparam logic [11:0] OFS_IRQ_FLAGS = 12'h00c;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
  localparam logic [11:0] OFS_MON_EN = 12'h014;
  localparam logic [11:0] OFS_LIVE = 12'h018;
  localparam logic [11:0] OFS_HIST_STAT = 12'h01c;
  localparam logic [11:0] OFS_HOLD_WORD = 12'h020;
  localparam logic [11:0] OFS_GPIO0 = 12'h024;
  // field positions
  localparam int CTRL_REC_EN = 0;
  localparam int CTRL_SOFT_RST = 1;
  localparam int CTRL_WIN_LSB = 4;
  localparam int IRQ_EN = 0;
  localparam int IRQ_POL = 1;
  localparam int IRQ_AND = 2;
  localparam int IRQ_CLR = 3;
  localparam int GPIO_SEL_LSB = 0;
  localparam int GPIO_POL = 4;
  localparam int GPIO_OD = 5;
  localparam logic [3:0] GPIO_SEL_IRQ = 4'h7;
  // reset values
  localparam logic [3:0] RST_WIN = 4'h4;
  localparam logic [6:0] RST_MON_EN = 7'h7f;
  localparam logic [6:0] RST_MASK = 7'h7f;
endpackage

// ### shared/dhh_gpio_if.sv
// carries per-pin status output configuration and the signals to route
// assumes one configuring side and one pin driver side
`timescale 1ns/1ps
`default_nettype none
interface dhh_gpio_if #(parameter int N = dhh_pkg::NGPIO);
  logic [N-1:0][3:0] sel;
  logic [N-1:0] pol;
  logic [N-1:0] od;
  logic [dhh_pkg::NSRC-1:0] status;
  logic irq;
  modport cfg (output sel, pol, od, status, irq);
  modport pin (input sel, pol, od, status, irq);
endinterface
`default_nettype wire

// ### src/dhh_sync.sv
// two flip-flop synchroniser for a vector of independent level signals
// assumes each bit is a slow level; no word coherence between bits
`timescale 1ns/1ps
`default_nettype none
module dhh_sync #(parameter int W = dhh_pkg::NSRC)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q <= '0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### src/dhh_gpio.sv
// status pin drivers: source select, polarity and driver type per pin
// assumes the pin pad resolves open-drain from out and oe
`timescale 1ns/1ps
`default_nettype none
module dhh_gpio #(parameter int N = dhh_pkg::NGPIO)
(
  input wire logic clk,
  input wire logic rst_n,
  dhh_gpio_if.pin cfg,
  output var logic [N-1:0] pin_out,
  output var logic [N-1:0] pin_oe
);
  logic [N-1:0] out_nxt;
  logic [N-1:0] oe_nxt;
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      logic v;
      always_comb
      begin
        v = 1'b0;
        if (cfg.sel[g] == dhh_pkg::GPIO_SEL_IRQ)
          v = cfg.irq;
        else if (cfg.sel[g] < 4'(dhh_pkg::NSRC))
          v = cfg.status[cfg.sel[g][2:0]];
        v = v ^ cfg.pol[g];
        // open drain only pulls low
        out_nxt[g] = cfg.od[g] ? 1'b0 : v;
        oe_nxt[g] = cfg.od[g] ? ~v : 1'b1;
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
    end
  end
endmodule
`default_nettype wire

// ### src/dhh_top.sv
// tuning word history, interrupt flags and status pins behind an apb slave
// assumes lf_word, lf_valid and dpll_mode come from logic on pclk;
// status_live comes from other domains and is synchronised here
`timescale 1ns/1ps
`default_nettype none
// How it works
// - output word is loop filter, history hold word or free-run word by mode
// - while enabled and locked, loop filter samples are summed and averaged
// - on input loss the stored average sets the holdover word
// - holdover entry drops the latest average and the partial sum
// - hard reset and soft reset clear all history
// - first window after a new lock is discarded before history starts
// - switchover and holdover exit keep the stored history
// - record enable going one, zero, one clears the history
// - with no history, holdover uses the unlocked default word
// - each status pin selects a source, polarity and driver type
// - any status pin can carry the interrupt
// - sources are oscillator, reference, three unlocks, holdover, switchover
// - polarity picks rising or falling edge to set a sticky flag
// - a masked flag does not reach the interrupt
// - unmasked flags combine by and or by or
// - host reads flags, then writes one to the clear field
// - a disabled source monitor never sets a flag and reads as clear
module dhh_top #(
  parameter int TW_W = dhh_pkg::TW_W,
  parameter int NGPIO = dhh_pkg::NGPIO
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dhh_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic [TW_W-1:0] lf_word,
  input wire logic lf_valid,
  input wire logic [1:0] dpll_mode,
  input wire logic [dhh_pkg::NSRC-1:0] status_live,
  output var logic [TW_W-1:0] tw_out,
  output var logic irq,
  output var logic [NGPIO-1:0] gpio_out,
  output var logic [NGPIO-1:0] gpio_oe
);
  localparam int NS = dhh_pkg::NSRC;
  localparam int AW = TW_W + dhh_pkg::CNT_W;
  dhh_gpio_if #(.N(NGPIO)) gif ();
  logic [NS-1:0] live;
  logic [31:0] prdata_nxt;
  logic pready_nxt, pslverr_nxt, hist_en_r, hist_en_nxt;
  logic [3:0] win_k_r, win_k_nxt;
  logic [TW_W-1:0] free_run_r, free_run_nxt;
  logic irq_en_r, irq_en_nxt, irq_pol_r, irq_pol_nxt, irq_and_r, irq_and_nxt, irq_nxt;
  logic [NS-1:0] flags_r, flags_nxt, mask_r, mask_nxt, mon_en_r, mon_en_nxt;
  logic [NS-1:0] live_prev_r, ev, unmasked;
  logic [NGPIO-1:0][3:0] gsel_r, gsel_nxt;
  logic [NGPIO-1:0] gpol_r, gpol_nxt, god_r, god_nxt;
  logic [AW-1:0] acc_r, acc_nxt, sum_w;
  logic [dhh_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [TW_W-1:0] latest_r, latest_nxt, older_r, older_nxt, hold_r, hold_nxt, tw_nxt;
  logic skip_r, skip_nxt, latest_v_r, latest_v_nxt, older_v_r, older_v_nxt, hist_v_r, hist_v_nxt;
  logic [1:0] mode_prev_r;
  logic wr_en, soft_rst, clr_all, win_end, enter_lock, enter_hold;
  dhh_pkg::dhh_mode_t mode;
  dhh_sync #(.W(NS)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(status_live),
    .q(live)
  );
  assign gif.sel = gsel_r;
  assign gif.pol = gpol_r;
  assign gif.od = god_r;
  assign gif.status = live & mon_en_r;
  assign gif.irq = irq;
  dhh_gpio #(.N(NGPIO)) u_gpio (
    .clk(pclk),
    .rst_n(presetn),
    .cfg(gif),
    .pin_out(gpio_out),
    .pin_oe(gpio_oe)
  );
  assign mode = dhh_pkg::dhh_mode_t'(dpll_mode);
  // zero-wait slave: pready rises in every access phase
  assign wr_en = psel && penable && pwrite && pready;
  assign soft_rst = wr_en && paddr == dhh_pkg::OFS_CTRL && pwdata[dhh_pkg::CTRL_SOFT_RST];
  assign clr_all = soft_rst || (wr_en && paddr == dhh_pkg::OFS_IRQ_CTRL && pwdata[dhh_pkg::IRQ_CLR]);
  assign enter_lock = mode == dhh_pkg::DHH_LOCK && mode_prev_r != 2'(dhh_pkg::DHH_LOCK);
  assign enter_hold = mode == dhh_pkg::DHH_HOLD && mode_prev_r != 2'(dhh_pkg::DHH_HOLD);
  assign sum_w = acc_r + AW'(lf_word);
  // power-of-two window keeps the average a shift, not a divider
  assign win_end = lf_valid && cnt_r == dhh_pkg::CNT_W'((17'h00001 << win_k_r) - 17'h00001);
  // register file and apb answers
  always_comb
  begin
    prdata_nxt = 32'h00000000;
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    hist_en_nxt = hist_en_r;
    win_k_nxt = win_k_r;
    free_run_nxt = free_run_r;
    irq_en_nxt = irq_en_r;
    irq_pol_nxt = irq_pol_r;
    irq_and_nxt = irq_and_r;
    mask_nxt = mask_r;
    mon_en_nxt = mon_en_r;
    gsel_nxt = gsel_r;
    gpol_nxt = gpol_r;
    god_nxt = god_r;
    if (psel && !penable)
    begin
      unique case (paddr)
        dhh_pkg::OFS_CTRL: prdata_nxt = {24'h000000, win_k_r, 3'h0, hist_en_r};
        dhh_pkg::OFS_FREE_RUN: prdata_nxt = 32'(free_run_r);
        dhh_pkg::OFS_IRQ_CTRL: prdata_nxt = {29'h00000000, irq_and_r, irq_pol_r, irq_en_r};
        dhh_pkg::OFS_IRQ_FLAGS: prdata_nxt = 32'(flags_r);
        dhh_pkg::OFS_IRQ_MASK: prdata_nxt = 32'(mask_r);
        dhh_pkg::OFS_MON_EN: prdata_nxt = 32'(mon_en_r);
        dhh_pkg::OFS_LIVE: prdata_nxt = 32'(live & mon_en_r);
        dhh_pkg::OFS_HIST_STAT: prdata_nxt = {26'h0000000, mode_prev_r, 1'b0, older_v_r, latest_v_r, hist_v_r};
        dhh_pkg::OFS_HOLD_WORD: prdata_nxt = 32'(hold_r);
        default:
        begin
          if (paddr >= dhh_pkg::OFS_GPIO0 && paddr < dhh_pkg::OFS_GPIO0 + 12'(4 * NGPIO) && paddr[1:0] == 2'h0)
          begin
            for (int i = 0; i < NGPIO; i++)
              if (paddr == dhh_pkg::OFS_GPIO0 + 12'(4 * i))
                prdata_nxt = {26'h0000000, god_r[i], gpol_r[i], gsel_r[i]};
          end
          else
            pslverr_nxt = 1'b1;
        end
      endcase
    end
    if (wr_en)
    begin
      unique case (paddr)
        dhh_pkg::OFS_CTRL:
        begin
          hist_en_nxt = pwdata[dhh_pkg::CTRL_REC_EN];
          win_k_nxt = pwdata[dhh_pkg::CTRL_WIN_LSB +: 4];
        end
        dhh_pkg::OFS_FREE_RUN: free_run_nxt = pwdata[TW_W-1:0];
        dhh_pkg::OFS_IRQ_CTRL:
        begin
          irq_en_nxt = pwdata[dhh_pkg::IRQ_EN];
          irq_pol_nxt = pwdata[dhh_pkg::IRQ_POL];
          irq_and_nxt = pwdata[dhh_pkg::IRQ_AND];
        end
        dhh_pkg::OFS_IRQ_MASK: mask_nxt = pwdata[NS-1:0];
        dhh_pkg::OFS_MON_EN: mon_en_nxt = pwdata[NS-1:0];
        default:
        begin
          for (int i = 0; i < NGPIO; i++)
            if (paddr == dhh_pkg::OFS_GPIO0 + 12'(4 * i))
            begin
              gsel_nxt[i] = pwdata[dhh_pkg::GPIO_SEL_LSB +: 4];
              gpol_nxt[i] = pwdata[dhh_pkg::GPIO_POL];
              god_nxt[i] = pwdata[dhh_pkg::GPIO_OD];
            end
        end
      endcase
    end
  end
  // sticky flags and interrupt output
  always_comb
  begin
    ev = (irq_pol_r ? (live & ~live_prev_r) : (~live & live_prev_r)) & mon_en_r & {NS{irq_en_r}};
    flags_nxt = flags_r;
    if (wr_en && paddr == dhh_pkg::OFS_IRQ_FLAGS)
      flags_nxt = flags_nxt & ~pwdata[NS-1:0];
    if (clr_all)
      flags_nxt = '0;
    flags_nxt = flags_nxt | ev;
    unmasked = flags_nxt & ~mask_nxt;
    if (irq_and_nxt)
      irq_nxt = irq_en_nxt && unmasked != '0 && (flags_nxt | mask_nxt) == {NS{1'b1}};
    else
      irq_nxt = irq_en_nxt && unmasked != '0;
  end
  // history averaging and tuning word source
  always_comb
  begin
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    skip_nxt = skip_r;
    latest_nxt = latest_r;
    latest_v_nxt = latest_v_r;
    older_nxt = older_r;
    older_v_nxt = older_v_r;
    hold_nxt = hold_r;
    hist_v_nxt = hist_v_r;
    if (!hist_en_r || soft_rst)
    begin
      acc_nxt = '0;
      cnt_nxt = '0;
      skip_nxt = 1'b1;
      latest_v_nxt = 1'b0;
      older_v_nxt = 1'b0;
      hist_v_nxt = 1'b0;
      hold_nxt = '0;
    end
    else if (enter_lock)
    begin
      acc_nxt = '0;
      cnt_nxt = '0;
      skip_nxt = 1'b1;
    end
    else if (mode == dhh_pkg::DHH_LOCK && lf_valid)
    begin
      acc_nxt = sum_w;
      cnt_nxt = cnt_r + 1'b1;
      if (win_end)
      begin
        acc_nxt = '0;
        cnt_nxt = '0;
        skip_nxt = 1'b0;
        if (!skip_r)
        begin
          older_nxt = latest_r;
          older_v_nxt = latest_v_r;
          latest_nxt = TW_W'(sum_w >> win_k_r);
          latest_v_nxt = 1'b1;
        end
      end
    end
    else if (enter_hold)
    begin
      acc_nxt = '0;
      cnt_nxt = '0;
      latest_v_nxt = 1'b0;
      older_v_nxt = 1'b0;
      // old history kept if none newer
      if (older_v_r)
      begin
        hold_nxt = older_r;
        hist_v_nxt = 1'b1;
      end
    end
    unique case (mode)
      dhh_pkg::DHH_LOCK: tw_nxt = lf_word;
      dhh_pkg::DHH_HOLD: tw_nxt = hist_v_nxt ? hold_nxt : free_run_r;
      dhh_pkg::DHH_FREE: tw_nxt = free_run_r;
      default: tw_nxt = free_run_r;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      hist_en_r <= 1'b0;
      win_k_r <= dhh_pkg::RST_WIN;
      free_run_r <= '0;
      irq_en_r <= 1'b0;
      irq_pol_r <= 1'b1;
      irq_and_r <= 1'b0;
      flags_r <= '0;
      mask_r <= dhh_pkg::RST_MASK;
      mon_en_r <= dhh_pkg::RST_MON_EN;
      live_prev_r <= '0;
      gsel_r <= '0;
      gpol_r <= '0;
      god_r <= '0;
      irq <= 1'b0;
      acc_r <= '0;
      cnt_r <= '0;
      skip_r <= 1'b1;
      latest_r <= '0;
      latest_v_r <= 1'b0;
      older_r <= '0;
      older_v_r <= 1'b0;
      hold_r <= '0;
      hist_v_r <= 1'b0;
      mode_prev_r <= 2'h0;
      tw_out <= '0;
    end
    else
    begin
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
      hist_en_r <= hist_en_nxt;
      win_k_r <= win_k_nxt;
      free_run_r <= free_run_nxt;
      irq_en_r <= irq_en_nxt;
      irq_pol_r <= irq_pol_nxt;
      irq_and_r <= irq_and_nxt;
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      mon_en_r <= mon_en_nxt;
      live_prev_r <= live;
      gsel_r <= gsel_nxt;
      gpol_r <= gpol_nxt;
      god_r <= god_nxt;
      irq <= irq_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      skip_r <= skip_nxt;
      latest_r <= latest_nxt;
      latest_v_r <= latest_v_nxt;
      older_r <= older_nxt;
      older_v_r <= older_v_nxt;
      hold_r <= hold_nxt;
      hist_v_r <= hist_v_nxt;
      mode_prev_r <= dpll_mode;
      tw_out <= tw_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  tw_locked_a: assert property (mode == dhh_pkg::DHH_LOCK |=> tw_out == $past(lf_word))
    else $error("locked word not from loop filter");
  avg_store_a: assert property (mode == dhh_pkg::DHH_LOCK && win_end && !skip_r && hist_en_r && !soft_rst && !enter_lock
    |=> latest_v_r && older_r == $past(latest_r))
    else $error("window end did not shift averages");
  hold_take_a: assert property (hist_en_r && !soft_rst && enter_hold && older_v_r
    |=> hold_r == $past(older_r) && hist_v_r)
    else $error("holdover word not taken from older average");
  hold_drop_a: assert property (hist_en_r && enter_hold |=> !latest_v_r && cnt_r == '0)
    else $error("latest average kept on holdover entry");
  hist_clear_a: assert property (!hist_en_r || soft_rst |=> !hist_v_r && !older_v_r && skip_r)
    else $error("history not cleared");
  first_skip_a: assert property (hist_en_r && !soft_rst && enter_lock |=> skip_r && !$changed(latest_v_r))
    else $error("first window not discarded");
  hold_default_a: assert property (mode == dhh_pkg::DHH_HOLD && !hist_v_r && !enter_hold |=> tw_out == $past(free_run_r))
    else $error("default word not used without history");
  flag_set_a: assert property (ev != '0 |=> (flags_r & $past(ev)) == $past(ev))
    else $error("edge did not set flag");
  flag_hold_a: assert property (flags_r != '0 && !wr_en |=> (flags_r & $past(flags_r)) == $past(flags_r))
    else $error("sticky flag dropped");
  mon_off_a: assert property (((flags_r & ~$past(flags_r)) & ~$past(mon_en_r)) == '0)
    else $error("disabled monitor set a flag");
  mask_out_a: assert property (((flags_r & ~mask_r) == '0) |-> !irq)
    else $error("masked flag drove interrupt");
  clear_a: assert property (clr_all |=> flags_r == $past(ev) && (flags_r != '0 || !irq))
    else $error("clear field did not clear flags");

  hold_entry_c: cover property (enter_hold && older_v_r);
  irq_fire_c: cover property ($rose(irq));
  irq_clear_c: cover property (irq ##1 clr_all ##2 !irq);
  toggle_clr_c: cover property (hist_v_r ##1 !hist_en_r ##[1:20] hist_en_r);
endmodule
`default_nettype wire

// ### bench/dhh_lf_model.sv
// loop filter stand-in: one-cycle sample strobes with a held tuning word
// assumes the testbench calls send from its main thread, one call at a time
`timescale 1ns/1ps
`default_nettype none
module dhh_lf_model
(
  input wire logic clk,
  output logic [31:0] word,
  output logic valid
);
  initial
  begin
    word = 32'h0;
    valid = 1'b0;
  end
  // gap of two cycles between samples, like a slow loop filter update
  task automatic send(input logic [31:0] w, input int n);
    repeat (n)
    begin
      @(posedge clk);
      valid <= 1'b1;
      word <= w;
      @(posedge clk);
      valid <= 1'b0;
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ### bench/dpll_holdover_history_irq_tb.sv
// register-level test of the holdover history, interrupt flags and status pins
// assumes zero-wait apb answers and the loop filter model in dhh_lf_model
`timescale 1ns/1ps
`default_nettype none
module dpll_holdover_history_irq_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] lf_word;
  logic lf_valid;
  logic [1:0] dpll_mode = 2'b00;
  logic [6:0] status_live = 7'h00;
  logic [31:0] tw_out;
  logic irq;
  logic [1:0] gpio_out;
  logic [1:0] gpio_oe;
  logic last_err;
  int fail_count = 0;
  int check_count = 0;
  localparam logic [31:0] FREE_W = 32'h1234_5678;

  always #50 pclk = ~pclk;

  dhh_lf_model lf (.clk(pclk), .word(lf_word), .valid(lf_valid));

  dhh_top uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lf_word(lf_word), .lf_valid(lf_valid), .dpll_mode(dpll_mode), .status_live(status_live),
    .tw_out(tw_out), .irq(irq), .gpio_out(gpio_out), .gpio_oe(gpio_oe)
  );

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fail_count++;
      stop_test();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // nwin full two-sample windows after a fresh lock, one partial sample, then holdover
  task automatic build_hist(input logic [31:0] base, input int nwin);
    dpll_mode <= 2'b00;
    repeat (2) @(posedge pclk);
    dpll_mode <= 2'b01;
    repeat (2) @(posedge pclk);
    for (int j = 0; j < nwin; j++)
    begin
      lf.send(base + 32'(j * 16), 1);
      lf.send(base + 32'(j * 16 + 2), 1);
    end
    lf.send(base + 32'h100, 1);
    repeat (2) @(posedge pclk);
    chk(tw_out, base + 32'h100);
    dpll_mode <= 2'b10;
    repeat (3) @(posedge pclk);
  endtask

  // pulse one live status bit; either polarity setting sees one edge of it
  task automatic pulse_src(input int i);
    status_live <= 7'(1 << i);
    repeat (6) @(posedge pclk);
    status_live <= 7'h00;
    repeat (6) @(posedge pclk);
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(dhh_pkg::OFS_CTRL, 32'h40);
    rd(dhh_pkg::OFS_IRQ_CTRL, 32'h2);
    rd(dhh_pkg::OFS_IRQ_MASK, 32'h7f);
    rd(dhh_pkg::OFS_MON_EN, 32'h7f);
    rd(12'h100, 32'h0);
    chk(32'(last_err), 32'h1);
    // mode selects the tuning word source
    wr(dhh_pkg::OFS_FREE_RUN, FREE_W);
    repeat (2) @(posedge pclk);
    chk(tw_out, FREE_W);
    dpll_mode <= 2'b11;
    repeat (2) @(posedge pclk);
    chk(tw_out, FREE_W);
    dpll_mode <= 2'b10;
    repeat (2) @(posedge pclk);
    chk(tw_out, FREE_W);
    rd(dhh_pkg::OFS_HIST_STAT, 32'h20);
    // window of two samples; first window after lock is thrown away
    wr(dhh_pkg::OFS_CTRL, 32'h11);
    build_hist(32'h1000, 2);
    chk(tw_out, FREE_W);
    build_hist(32'h2000, 3);
    chk(tw_out, 32'h2011);
    rd(dhh_pkg::OFS_HOLD_WORD, 32'h2011);
    dpll_mode <= 2'b01;
    repeat (2) @(posedge pclk);
    dpll_mode <= 2'b10;
    repeat (3) @(posedge pclk);
    chk(tw_out, 32'h2011);
    wr(dhh_pkg::OFS_CTRL, 32'h10);
    wr(dhh_pkg::OFS_CTRL, 32'h11);
    repeat (2) @(posedge pclk);
    chk(tw_out, FREE_W);
    build_hist(32'h3000, 3);
    chk(tw_out, 32'h3011);
    wr(dhh_pkg::OFS_CTRL, 32'h13);
    repeat (2) @(posedge pclk);
    chk(tw_out, FREE_W);
    // every source sets its flag on a rising edge and holds it
    wr(dhh_pkg::OFS_IRQ_MASK, 32'h0);
    wr(dhh_pkg::OFS_IRQ_CTRL, 32'h3);
    for (int i = 0; i < 7; i++)
    begin
      pulse_src(i);
      chk(32'(irq), 32'h1);
      rd(dhh_pkg::OFS_IRQ_FLAGS, 32'(1 << i));
      wr(dhh_pkg::OFS_IRQ_CTRL, 32'hb);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      rd(dhh_pkg::OFS_IRQ_FLAGS, 32'h0);
    end
    // low polarity: only the falling edge counts
    wr(dhh_pkg::OFS_IRQ_CTRL, 32'h1);
    status_live <= 7'h01;
    repeat (6) @(posedge pclk);
    chk(32'(irq), 32'h0);
    status_live <= 7'h00;
    repeat (6) @(posedge pclk);
    chk(32'(irq), 32'h1);
    wr(dhh_pkg::OFS_IRQ_FLAGS, 32'h1);
    rd(dhh_pkg::OFS_IRQ_FLAGS, 32'h0);
    wr(dhh_pkg::OFS_IRQ_MASK, 32'h01);
    pulse_src(0);
    rd(dhh_pkg::OFS_IRQ_FLAGS, 32'h1);
    chk(32'(irq), 32'h0);
    // and-combine over the two unmasked flags
    wr(dhh_pkg::OFS_IRQ_MASK, 32'h7c);
    wr(dhh_pkg::OFS_IRQ_CTRL, 32'h5);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    pulse_src(1);
    chk(32'(irq), 32'h1);
    // a disabled monitor neither flags nor reads back
    wr(dhh_pkg::OFS_IRQ_CTRL, 32'hb);
    wr(dhh_pkg::OFS_IRQ_MASK, 32'h0);
    wr(dhh_pkg::OFS_MON_EN, 32'h7b);
    status_live <= 7'h04;
    repeat (6) @(posedge pclk);
    rd(dhh_pkg::OFS_LIVE, 32'h0);
    status_live <= 7'h00;
    repeat (6) @(posedge pclk);
    pulse_src(2);
    rd(dhh_pkg::OFS_IRQ_FLAGS, 32'h0);
    // pin 0 carries the interrupt, pin 1 source 0 as open drain
    wr(dhh_pkg::OFS_GPIO0, 32'h07);
    wr(12'h028, 32'h20);
    repeat (2) @(posedge pclk);
    chk(32'(gpio_out[0]), 32'h0);
    chk(32'(gpio_oe[1]), 32'h1);
    status_live <= 7'h01;
    repeat (6) @(posedge pclk);
    chk(32'(gpio_oe[1]), 32'h0);
    chk(32'(gpio_out[1]), 32'h0);
    status_live <= 7'h00;
    repeat (6) @(posedge pclk);
    chk(32'(gpio_out[0]), 32'h1);
    chk(32'(gpio_oe[0]), 32'h1);
    wr(dhh_pkg::OFS_GPIO0, 32'h17);
    repeat (2) @(posedge pclk);
    chk(32'(gpio_out[0]), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
